// [pkg/fbra_pkg.sv]
package fbra_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int SECT_W = 7;
  // ----------------------------------------------------------------
  // address field positions
  // ----------------------------------------------------------------
  localparam int ADDR_BIT_ZERO_POS = 0;
  localparam int ADDR_BIT_ONE_POS  = 1;
  localparam int ADDR_BIT_SIX_POS  = 6;
  localparam int SECTOR_LSB_POS    = 12;
  localparam int DATA_BIT_ZERO_POS = 0;
  localparam int DATA_BIT_SEVEN_POS = 7;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int ACCESS_TIME_NS = 150;  // slowest access grade
  localparam int ACCESS_CYC     = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_TIME_NS  = 200;
  localparam int SLEEP_CYC      = (SLEEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 4;
  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FBRA_OP_READ   = 2'h0,
    FBRA_OP_MAKER  = 2'h1,
    FBRA_OP_DEVID  = 2'h2,
    FBRA_OP_PROT   = 2'h3
  } fbra_op_t;
  typedef enum logic [1:0] {
    FBRA_IDLE = 2'h0,
    FBRA_SETUP = 2'h1,
    FBRA_WAIT = 2'h3,
    FBRA_DONE = 2'h2
  } fbra_state_t;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
endpackage

// [core/fbra_sync.sv]
`timescale 1ns/10ps
module fbra_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         en_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  // ----------------------------------------------------------------
  // two flop synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_reg <= '0;
      q_o      <= '0;
    end
    else if (en_i)
    begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule

// [core/fbra_host.sv]
`timescale 1ns/10ps
// What this block does
// R1: data read only with select, enable low, strobe high
// R2: deselect with reset high gives standby
// R3: standby floats data regardless of enable
// R4: busy algorithm finishes before standby
// R5: sleep after address stable 200 ns
// R6: sleep depends only on address stability
// R7: sleep keeps output; new address reads normally
// R8: enable high floats all data pins
// R9: high voltage pin: bit zero picks maker/device
// R10: identifier mode: drive only bits zero, one, six
// R11: identifier bytes carry odd parity on bit seven
// R12: word device id fixed upper byte; else float
// R13: protection query: bit one high, sector bits
// R14: ids also readable by command sequence; here write strobe is held high, ids read only via the high voltage pin
// R15: reset low floats data, array read mode
// R16: width pin high word, low byte mode
// R17: qualifier input and counted sleep interval
module fbra_host
  import fbra_pkg::*;
#(
  parameter int ACC_CYC = ACCESS_CYC
) (
  // clock, reset, enable
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  ce_i,
  // user request
  input  wire logic                  req_i,
  input  wire fbra_pkg::fbra_op_t    op_i,
  input  wire logic [fbra_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                  word_mode_i,
  input  wire logic                  flash_reset_i,
  // user answer
  output logic                       busy_o,
  output logic                       done_o,
  output logic [fbra_pkg::DATA_W-1:0] rdata_o,
  output logic                       parity_ok_o,
  output logic                       protected_o,
  output logic                       addr_idle_o,
  // flash pins
  output logic                       chip_sel_b_o,
  output logic                       out_en_b_o,
  output logic                       wr_en_b_o,
  output logic                       reset_b_o,
  output logic                       word_sel_o,
  output logic                       identifier_hv_address_pin_o,
  output logic [fbra_pkg::ADDR_W-1:0] addr_o,
  input  wire logic [fbra_pkg::DATA_W-1:0] dq_i
);
  import fbra_pkg::*;

  fbra_state_t          state_reg, state_next;
  logic [CNT_W-1:0]     cnt_reg, cnt_next;
  logic [CNT_W-1:0]     idle_reg, idle_next;
  fbra_op_t             op_reg, op_next;
  logic                 cs_reg, cs_next, oe_reg, oe_next, hv_reg, hv_next, rst_reg, rst_next;
  logic                 word_reg, word_next, done_reg, done_next, idle_o_reg, idle_o_next;
  logic                 busy_reg, busy_next;
  logic                 par_reg, par_next, prot_reg, prot_next;
  logic [ADDR_W-1:0]    addr_reg, addr_next;
  logic [DATA_W-1:0]    data_reg, data_next;
  logic [DATA_W-1:0]    dq_s;

  // ----------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------
  fbra_sync #(.W(DATA_W)) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .en_i    (ce_i),
    .d_i     (dq_i),
    .q_o     (dq_s)
  );

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    op_next     = op_reg;
    cs_next     = cs_reg;
    oe_next     = oe_reg;
    hv_next     = hv_reg;
    addr_next   = addr_reg;
    word_next   = word_reg;
    data_next   = data_reg;
    par_next    = par_reg;
    prot_next   = prot_reg;
    done_next   = 1'b0;
    rst_next    = flash_reset_i;
    idle_next   = (idle_reg == CNT_W'(SLEEP_CYC)) ? idle_reg : idle_reg + 1'b1;
    idle_o_next = (idle_reg == CNT_W'(SLEEP_CYC));  // R5 R6 R17
    unique case (state_reg)
      FBRA_IDLE:
      begin
        cs_next = 1'b1;  // R2 R3 deselect between accesses
        oe_next = 1'b1;  // R8
        if (req_i && flash_reset_i)
        begin
          op_next   = op_i;
          word_next = word_mode_i;  // R16
          hv_next   = (op_i != FBRA_OP_READ);  // R9 R17
          // identifier mode drives only bits zero, one, six, plus sector bits for the protection query (R10 R13)
          if (op_i == FBRA_OP_READ)
            addr_next = addr_i;
          else
          begin
            addr_next = '0;
            addr_next[ADDR_BIT_ZERO_POS] = (op_i == FBRA_OP_DEVID);  // R9
            addr_next[ADDR_BIT_ONE_POS]  = (op_i == FBRA_OP_PROT);   // R10 R13
            addr_next[ADDR_BIT_SIX_POS]  = 1'b0;
            if (op_i == FBRA_OP_PROT)
              addr_next[ADDR_W-1:SECTOR_LSB_POS] = addr_i[ADDR_W-1:SECTOR_LSB_POS];  // R13
          end
          if (addr_next != addr_reg)
            idle_next = '0;  // R7 address change restarts sleep timer
          state_next = FBRA_SETUP;
        end
      end
      FBRA_SETUP:
      begin
        cs_next    = 1'b0;  // R1
        oe_next    = 1'b0;  // R1
        cnt_next   = '0;
        state_next = FBRA_WAIT;
      end
      FBRA_WAIT:
      begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(ACC_CYC + 2))  // access time plus sync delay
        begin
          data_next = dq_s;
          if (op_reg == FBRA_OP_DEVID && word_reg)
            data_next = dq_s;  // R12 full word
          else if (op_reg != FBRA_OP_READ || !word_reg)
            data_next[DATA_W-1:8] = 8'h00;  // R12 upper pins float
          par_next  = ^dq_s[DATA_BIT_SEVEN_POS:0];  // R11 odd parity
          prot_next = (op_reg == FBRA_OP_PROT) && dq_s[DATA_BIT_ZERO_POS];  // R13
          state_next = FBRA_DONE;
        end
      end
      FBRA_DONE:
      begin
        cs_next    = 1'b1;
        oe_next    = 1'b1;
        hv_next    = 1'b0;
        done_next  = 1'b1;
        state_next = FBRA_IDLE;
      end
    endcase
    if (!flash_reset_i)  // R15 reset returns to array read
    begin
      state_next = FBRA_IDLE;
      cs_next    = 1'b1;
      oe_next    = 1'b1;
      hv_next    = 1'b0;
    end
    // busy follows the state that the next edge loads, so the pin is a flop
    busy_next = (state_next != FBRA_IDLE);
  end

  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg  <= FBRA_IDLE;
      cnt_reg    <= '0;
      idle_reg   <= '0;
      op_reg     <= FBRA_OP_READ;
      cs_reg     <= 1'b1;
      oe_reg     <= 1'b1;
      hv_reg     <= 1'b0;
      rst_reg    <= 1'b0;
      word_reg   <= 1'b1;
      done_reg   <= 1'b0;
      busy_reg   <= 1'b0;
      idle_o_reg <= 1'b0;
      par_reg    <= 1'b0;
      prot_reg   <= 1'b0;
      addr_reg   <= '0;
      data_reg   <= DATA_RST;
    end
    else if (ce_i)
    begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      idle_reg   <= idle_next;
      op_reg     <= op_next;
      cs_reg     <= cs_next;
      oe_reg     <= oe_next;
      hv_reg     <= hv_next;
      rst_reg    <= rst_next;
      word_reg   <= word_next;
      done_reg   <= done_next;
      busy_reg   <= busy_next;
      idle_o_reg <= idle_o_next;
      par_reg    <= par_next;
      prot_reg   <= prot_next;
      addr_reg   <= addr_next;
      data_reg   <= data_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign chip_sel_b_o                = cs_reg;
  assign out_en_b_o                  = oe_reg;
  assign wr_en_b_o                   = 1'b1;  // R1 R14 strobe held high, no writes
  assign reset_b_o                   = rst_reg;
  assign word_sel_o                  = word_reg;
  assign identifier_hv_address_pin_o = hv_reg;
  assign addr_o                      = addr_reg;
  assign busy_o                      = busy_reg;
  assign done_o                      = done_reg;
  assign rdata_o                     = data_reg;
  assign parity_ok_o                 = par_reg;
  assign protected_o                 = prot_reg;
  assign addr_idle_o                 = idle_o_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_READ_GATE: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R1
    !oe_reg |-> (!cs_reg && wr_en_b_o)) else $error("enable without select");
  AST_RESET_FLOAT: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R15
    (ce_i && !flash_reset_i) |=> (cs_reg && oe_reg && !hv_reg)) else $error("reset not idle");
  AST_HV_MAKER: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R9
    (hv_reg && op_reg == FBRA_OP_MAKER && state_reg == FBRA_WAIT) |-> !addr_reg[0])
    else $error("maker address bit zero");
  AST_HV_BITONE: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R10
    (hv_reg && op_reg != FBRA_OP_PROT) |-> !addr_reg[1]) else $error("bit one not low");
  AST_PROT_ADDR: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R13
    (hv_reg && op_reg == FBRA_OP_PROT) |-> (addr_reg[1] && !addr_reg[0]))
    else $error("protect query address");
  AST_DONE_PULSE: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R1
    done_reg |-> (cs_reg && oe_reg)) else $error("done while selected");
  AST_SLEEP_FLAG: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R5
    (ce_i && idle_reg == CNT_W'(SLEEP_CYC)) |=> idle_o_reg) else $error("idle flag late");
  AST_WORD_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R16
    (state_reg == FBRA_WAIT && ce_i) |=> $stable(word_reg)) else $error("width changed");
endmodule

// [sim/fbra_flash_model.sv]
`timescale 1ns/10ps
module fbra_flash_model
  import fbra_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h07,  // arbitrary value, odd parity
  parameter logic [7:0] DEV_CODE   = 8'h8C   // arbitrary value, odd parity
) (
  // control pins
  input  wire logic                        chip_sel_b_i,
  input  wire logic                        out_en_b_i,
  input  wire logic                        wr_en_b_i,
  input  wire logic                        reset_b_i,
  input  wire logic                        word_sel_i,
  input  wire logic                        hv_i,
  // address and data
  input  wire logic [fbra_pkg::ADDR_W-1:0] addr_i,
  output logic      [fbra_pkg::DATA_W-1:0] dq_o
);
  logic [DATA_W-1:0] word_val;
  logic              drive;
  logic              hi_drive;
  // standby, reset and output disable all float the bus
  // no internal algorithm or command sequence is modelled, so deselect idles at once
  assign drive = !chip_sel_b_i && !out_en_b_i && wr_en_b_i && reset_b_i;
  // data source picked by the identifier level and address bits
  always_comb
  begin
    hi_drive = word_sel_i;
    if (!hv_i)
      word_val = addr_i[15:0] ^ 16'h5A3C;
    else if (addr_i[ADDR_BIT_ONE_POS])
    begin
      word_val = {15'h0000, addr_i[SECTOR_LSB_POS]};
      hi_drive = 1'b0;
    end
    else if (addr_i[ADDR_BIT_ZERO_POS])
      word_val = {8'h22, DEV_CODE};
    else
    begin
      word_val = {8'h00, MAKER_CODE};
      hi_drive = 1'b0;
    end
  end
  // floating lines show the inverse, never a stale copy
  assign #(ACCESS_TIME_NS) dq_o = {(drive && hi_drive) ? word_val[15:8] : ~word_val[15:8],
                                   drive ? word_val[7:0] : ~word_val[7:0]};
endmodule

// [sim/tb.sv]
`timescale 1ns/10ps
module tb;
  import fbra_pkg::*;
  localparam logic [7:0] MK = 8'h07;
  localparam logic [7:0] DV = 8'h8C;
  logic              clk_i, rst_b_i, ce_i, req_i, word_mode_i, flash_reset_i;
  fbra_op_t          op_i;
  logic [ADDR_W-1:0] addr_i, addr_o;
  logic [DATA_W-1:0] rdata_o, dq;
  logic              busy_o, done_o, parity_ok_o, protected_o, addr_idle_o, idle_seen;
  logic              chip_sel_b_o, out_en_b_o, wr_en_b_o, reset_b_o, word_sel_o, hv_o;
  int                failures = 0;
  int                tests_run = 0;
  // design and flash model
  fbra_host DUT (.clk_i, .rst_b_i, .ce_i, .req_i, .op_i, .addr_i, .word_mode_i,
    .flash_reset_i, .busy_o, .done_o, .rdata_o, .parity_ok_o, .protected_o, .addr_idle_o,
    .chip_sel_b_o, .out_en_b_o, .wr_en_b_o, .reset_b_o, .word_sel_o,
    .identifier_hv_address_pin_o(hv_o), .addr_o, .dq_i(dq));
  fbra_flash_model #(.MAKER_CODE(MK), .DEV_CODE(DV)) flash (.chip_sel_b_i(chip_sel_b_o),
    .out_en_b_i(out_en_b_o), .wr_en_b_i(wr_en_b_o), .reset_b_i(reset_b_o),
    .word_sel_i(word_sel_o), .hv_i(hv_o), .addr_i(addr_o), .dq_o(dq));
  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // compare helpers
  task automatic chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_data({15'h0000, got}, {15'h0000, exp});
  endtask
  // one request: pins while the flash drives, then the result
  task automatic run_op(input fbra_op_t op, input logic [ADDR_W-1:0] a, input logic w,
                        input logic [DATA_W-1:0] exp);
    int n;
    @(negedge clk_i);
    op_i = op;
    {addr_i, word_mode_i, req_i} = {a, w, 1'b1};
    @(negedge clk_i);
    req_i = 1'b0;
    for (n = 0; n < 20 && out_en_b_o !== 1'b0; n++) @(negedge clk_i);
    chk_flag(chip_sel_b_o, 1'b0);
    chk_flag(wr_en_b_o, 1'b1);
    chk_flag(word_sel_o, w);
    chk_flag(hv_o, op != FBRA_OP_READ);
    if (op != FBRA_OP_READ)
      chk_data({14'h0000, addr_o[1:0]}, {14'h0000, op == FBRA_OP_PROT, op == FBRA_OP_DEVID});
    else
      chk_data(addr_o[15:0], a[15:0]);
    if (op == FBRA_OP_PROT)
      chk_data({9'h000, addr_o[18:12]}, {9'h000, a[18:12]});
    repeat (2) @(negedge clk_i);
    idle_seen = addr_idle_o;
    for (n = 0; n < 20 && done_o !== 1'b1; n++) @(negedge clk_i);
    chk_flag(done_o, 1'b1);
    chk_data(rdata_o, exp);
    chk_flag(parity_ok_o, ^exp[7:0]);
    @(negedge clk_i);
    chk_flag(chip_sel_b_o, 1'b1);
    chk_flag(done_o, 1'b0);
  endtask
  // array reads in both widths
  task automatic read_case;
    run_op(FBRA_OP_READ, 19'h12345, 1'b1, 16'h2345 ^ 16'h5A3C);
    run_op(FBRA_OP_READ, 19'h0ABCD, 1'b0, {8'h00, 8'hCD ^ 8'h3C});
  endtask
  // identifier codes in both widths
  task automatic id_case;
    run_op(FBRA_OP_MAKER, 19'h7FFFF, 1'b1, {8'h00, MK});
    run_op(FBRA_OP_DEVID, 19'h7FFFF, 1'b1, {8'h22, DV});
    run_op(FBRA_OP_MAKER, 19'h00000, 1'b0, {8'h00, MK});
    run_op(FBRA_OP_DEVID, 19'h00000, 1'b0, {8'h00, DV});
  endtask
  // protected and unprotected sectors
  task automatic prot_case;
    run_op(FBRA_OP_PROT, 19'h05000, 1'b1, 16'h0001);
    chk_flag(protected_o, 1'b1);
    run_op(FBRA_OP_PROT, 19'h7E000, 1'b1, 16'h0000);
    chk_flag(protected_o, 1'b0);
  endtask
  // address-stable flag rises and drops
  task automatic idle_case;
    repeat (6) @(negedge clk_i);
    chk_flag(addr_idle_o, 1'b1);
    run_op(FBRA_OP_READ, 19'h00041, 1'b1, 16'h0041 ^ 16'h5A3C);
    chk_flag(idle_seen, 1'b0);
  endtask
  // flash reset aborts a read without a done pulse
  task automatic abort_case;
    int d;
    @(negedge clk_i);
    op_i = FBRA_OP_READ;
    {addr_i, req_i} = {19'h00123, 1'b1};
    @(negedge clk_i);
    req_i = 1'b0;
    flash_reset_i = 1'b0;
    d = 0;
    repeat (12) @(negedge clk_i) d += done_o;
    chk_flag(reset_b_o, 1'b0);
    chk_flag(busy_o, 1'b0);
    chk_data(d[15:0], 16'h0000);
    flash_reset_i = 1'b1;
    run_op(FBRA_OP_READ, 19'h00123, 1'b1, 16'h0123 ^ 16'h5A3C);
  endtask
  // clock enable low freezes a request in flight
  task automatic freeze_case;
    int n;
    @(negedge clk_i);
    op_i = FBRA_OP_READ;
    {addr_i, word_mode_i, req_i} = {19'h00200, 1'b1, 1'b1};
    @(negedge clk_i);
    {req_i, ce_i} = 2'b00;
    repeat (4) @(negedge clk_i);
    chk_flag(out_en_b_o, 1'b1);
    chk_flag(busy_o, 1'b1);
    ce_i = 1'b1;
    for (n = 0; n < 20 && done_o !== 1'b1; n++) @(negedge clk_i);
    chk_flag(done_o, 1'b1);
    chk_data(rdata_o, 16'h0200 ^ 16'h5A3C);
    @(negedge clk_i);
  endtask
  // verdict
  task automatic results;
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {rst_b_i, ce_i, req_i, word_mode_i, flash_reset_i} = 5'b01011;
    op_i = FBRA_OP_READ;
    addr_i = 19'h00000;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'b1;
    read_case;
    id_case;
    prot_case;
    idle_case;
    abort_case;
    freeze_case;
    results;
  end
  // watchdog
  initial
  begin
    #1000000;
    failures++;
    results;
  end
endmodule
